// file: hdl/ssau_pkg.sv
package ssau_pkg;
	// Operation select codes
	typedef enum logic [3:0] {
		SSAU_OP_NONE           = 4'b0000,
		SSAU_SIGNED_ADD_SUB_X  = 4'b0001,
		SSAU_SIGNED_SUB_ADD_X  = 4'b0010,
		SSAU_SIGNED_DBL_ADD    = 4'b0011,
		SSAU_SIGNED_DBL_SUB    = 4'b0100,
		SSAU_UNSIGNED_ADD_SUB_X = 4'b0101,
		SSAU_UNSIGNED_SUB_ADD_X = 4'b0110,
		SSAU_UNSIGNED_BYTE_ADD = 4'b0111,
		SSAU_UNSIGNED_HALF_ADD = 4'b1000,
		SSAU_UNSIGNED_BYTE_SUB = 4'b1001,
		SSAU_UNSIGNED_HALF_SUB = 4'b1010
	} ssau_op_e;

	localparam int          SSAU_DATA_W   = 32;
	localparam logic [31:0] SSAU_RES_RST  = 32'h0000_0000;
	localparam logic        SSAU_Q_RST    = 1'b0;
	localparam logic [3:0]  SSAU_FLAG_RST = 4'h0;
	localparam logic [15:0] SSAU_S16_MAX  = 16'h7fff;
	localparam logic [15:0] SSAU_S16_MIN  = 16'h8000;
	localparam logic [31:0] SSAU_S32_MAX  = 32'h7fff_ffff;
	localparam logic [31:0] SSAU_S32_MIN  = 32'h8000_0000;
	localparam logic [15:0] SSAU_U16_MAX  = 16'hffff;
	localparam logic [7:0]  SSAU_U8_MAX   = 8'hff;
endpackage : ssau_pkg

// file: hdl/ssau_unit.sv
`timescale 1ns/1ps
// Summary of operation
// - Signed add-sub-exchange: upper = sat16(a.hi + b.lo)
// - Signed add-sub-exchange: lower = sat16(a.lo - b.hi)
// - Signed sub-add-exchange: upper = sat16(a.hi - b.lo)
// - Signed sub-add-exchange: lower = sat16(a.lo + b.hi)
// - Signed exchange operations leave N, Z, C, V unchanged
// - Doubling add: sat32(a + sat32(2*b))
// - Doubling subtract: sat32(a - sat32(2*b))
// - Doubling ops set sticky Q on either clamp, else keep it
// - Unsigned add-sub-exchange: upper = usat16(a.hi + b.lo)
// - Unsigned add-sub-exchange: lower = usat16(a.lo - b.hi)
// - Unsigned sub-add-exchange: upper = usat16(a.hi - b.lo)
// - Unsigned sub-add-exchange: lower = usat16(a.lo + b.hi)
// - Unsigned exchange operations leave N, Z, C, V unchanged
// - Byte add: four lanes each clamped to 0..255
// - Halfword add: two lanes each clamped to 0..65535
// - Byte subtract: four lanes, negative differences become zero
// - Halfword subtract: two lanes, negative differences become zero
// - Sticky Q cleared only by reset or explicit status register write
// - Halfword add pairs top with top, bottom with bottom
module ssau_unit
	import ssau_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        resetn_i,
	input  wire logic        issue_i,
	input  wire logic        cond_pass_i,
	input  wire ssau_op_e    op_i,
	input  wire logic [31:0] first_i,
	input  wire logic [31:0] second_i,
	input  wire logic        psr_write_i,
	input  wire logic        psr_q_i,
	input  wire logic [3:0]  psr_nzcv_i,
	output logic      [31:0] result_o,
	output logic             result_valid_o,
	output logic             sticky_q_o,
	output logic      [3:0]  nzcv_o
);

	// ------------------------------------------------------------
	// Saturation helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] ssau_sat_s16(input logic [16:0] v);
		if (v[16] != v[15]) begin
			return v[16] ? SSAU_S16_MIN : SSAU_S16_MAX;
		end
		return v[15:0];
	endfunction : ssau_sat_s16

	function automatic logic [31:0] ssau_sat_s32(input logic [32:0] v);
		if (v[32] != v[31]) begin
			return v[32] ? SSAU_S32_MIN : SSAU_S32_MAX;
		end
		return v[31:0];
	endfunction : ssau_sat_s32

	function automatic logic ssau_ovf(input logic [32:0] v);
		return v[32] != v[31];
	endfunction : ssau_ovf

	// Unsigned add: carry out means clamp high
	function automatic logic [15:0] ssau_uadd16(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[16] ? SSAU_U16_MAX : s[15:0];
	endfunction : ssau_uadd16

	// Unsigned subtract: borrow means clamp to zero
	function automatic logic [15:0] ssau_usub16(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] d;
		d = {1'b0, a} - {1'b0, b};
		return d[16] ? 16'h0000 : d[15:0];
	endfunction : ssau_usub16

	function automatic logic [7:0] ssau_uadd8(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[8] ? SSAU_U8_MAX : s[7:0];
	endfunction : ssau_uadd8

	function automatic logic [7:0] ssau_usub8(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] d;
		d = {1'b0, a} - {1'b0, b};
		return d[8] ? 8'h00 : d[7:0];
	endfunction : ssau_usub8

	function automatic logic [16:0] ssau_sx(input logic [15:0] h);
		return {h[15], h};
	endfunction : ssau_sx

	// ------------------------------------------------------------
	// Datapath
	// ------------------------------------------------------------
	logic [15:0] a_hi;
	logic [15:0] a_lo;
	logic [15:0] b_hi;
	logic [15:0] b_lo;
	logic [32:0] dbl_raw;
	logic [31:0] dbl_sat;
	logic [32:0] acc_raw;
	logic [31:0] next_result;
	logic        next_sat;
	logic        exec;

	assign a_hi = first_i[31:16];
	assign a_lo = first_i[15:0];
	assign b_hi = second_i[31:16];
	assign b_lo = second_i[15:0];
	assign exec = issue_i && cond_pass_i;

	assign dbl_raw = {second_i, 1'b0};
	assign dbl_sat = ssau_sat_s32(dbl_raw);

	always_comb begin
		next_result = SSAU_RES_RST;
		next_sat    = 1'b0;
		acc_raw     = 33'h0_0000_0000;
		case (op_i)
			SSAU_SIGNED_ADD_SUB_X: begin
				next_result[31:16] = ssau_sat_s16(ssau_sx(a_hi) + ssau_sx(b_lo));
				next_result[15:0]  = ssau_sat_s16(ssau_sx(a_lo) - ssau_sx(b_hi));
			end
			SSAU_SIGNED_SUB_ADD_X: begin
				next_result[31:16] = ssau_sat_s16(ssau_sx(a_hi) - ssau_sx(b_lo));
				next_result[15:0]  = ssau_sat_s16(ssau_sx(a_lo) + ssau_sx(b_hi));
			end
			SSAU_SIGNED_DBL_ADD: begin
				acc_raw     = {first_i[31], first_i} + {dbl_sat[31], dbl_sat};
				next_result = ssau_sat_s32(acc_raw);
				next_sat    = ssau_ovf(dbl_raw) || ssau_ovf(acc_raw);
			end
			SSAU_SIGNED_DBL_SUB: begin
				acc_raw     = {first_i[31], first_i} - {dbl_sat[31], dbl_sat};
				next_result = ssau_sat_s32(acc_raw);
				next_sat    = ssau_ovf(dbl_raw) || ssau_ovf(acc_raw);
			end
			SSAU_UNSIGNED_ADD_SUB_X: begin
				next_result[31:16] = ssau_uadd16(a_hi, b_lo);
				next_result[15:0]  = ssau_usub16(a_lo, b_hi);
			end
			SSAU_UNSIGNED_SUB_ADD_X: begin
				next_result[31:16] = ssau_usub16(a_hi, b_lo);
				next_result[15:0]  = ssau_uadd16(a_lo, b_hi);
			end
			SSAU_UNSIGNED_BYTE_ADD: begin
				for (int i = 0; i < 4; i++) begin
					next_result[i*8 +: 8] = ssau_uadd8(first_i[i*8 +: 8], second_i[i*8 +: 8]);
				end
			end
			SSAU_UNSIGNED_HALF_ADD: begin
				next_result[31:16] = ssau_uadd16(a_hi, b_hi);
				next_result[15:0]  = ssau_uadd16(a_lo, b_lo);
			end
			SSAU_UNSIGNED_BYTE_SUB: begin
				for (int i = 0; i < 4; i++) begin
					next_result[i*8 +: 8] = ssau_usub8(first_i[i*8 +: 8], second_i[i*8 +: 8]);
				end
			end
			SSAU_UNSIGNED_HALF_SUB: begin
				next_result[31:16] = ssau_usub16(a_hi, b_hi);
				next_result[15:0]  = ssau_usub16(a_lo, b_lo);
			end
			default: begin
				next_result = SSAU_RES_RST;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Result register
	// ------------------------------------------------------------
	// Result held unless executed
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			result_o <= SSAU_RES_RST;
		end else if (exec && op_i != SSAU_OP_NONE) begin
			result_o <= next_result;
		end
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			result_valid_o <= 1'b0;
		end else begin
			result_valid_o <= exec && op_i != SSAU_OP_NONE;
		end
	end

	// ------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------
	// Set wins over an explicit clear in the same cycle
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sticky_q_o <= SSAU_Q_RST;
		end else if (exec && next_sat) begin
			sticky_q_o <= 1'b1;
		end else if (psr_write_i) begin
			sticky_q_o <= psr_q_i;
		end
	end

	// No operation here touches N, Z, C, V
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			nzcv_o <= SSAU_FLAG_RST;
		end else if (psr_write_i) begin
			nzcv_o <= psr_nzcv_i;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// Condition false holds result
	cond_false_hold_a: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		issue_i && !cond_pass_i |=> $stable(result_o) && !result_valid_o)
		else $error("Result changed on failed condition");

	none_op_hold_a: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		issue_i && op_i == SSAU_OP_NONE |=> $stable(result_o) && !result_valid_o)
		else $error("Result changed on empty operation");

	valid_pulse_a: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		exec && op_i != SSAU_OP_NONE |=> result_valid_o)
		else $error("Executed operation gave no valid pulse");

	dbl_sat_sets_q_a: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		exec && op_i == SSAU_SIGNED_DBL_ADD && (second_i[31] != second_i[30]) |=> sticky_q_o)
		else $error("Doubling clamp did not set Q");

	dbl_sub_floor_a: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		exec && op_i == SSAU_SIGNED_DBL_SUB && first_i == SSAU_S32_MIN && !second_i[31]
		&& second_i != 32'h0000_0000 |=> result_o == SSAU_S32_MIN && sticky_q_o)
		else $error("Doubling subtract did not clamp low");

	q_no_self_clear_a: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		sticky_q_o && !psr_write_i |=> sticky_q_o)
		else $error("Q cleared without status write");

	nzcv_stable_a: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		!psr_write_i |=> $stable(nzcv_o))
		else $error("Condition flags changed by arithmetic");

	nzcv_write_a: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		psr_write_i |=> nzcv_o == $past(psr_nzcv_i))
		else $error("Condition flags did not take status write");

	byte_add_top_a: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		exec && op_i == SSAU_UNSIGNED_BYTE_ADD && first_i[31:24] == 8'hff
		&& second_i[31:24] != 8'h00 |=> result_o[31:24] == SSAU_U8_MAX)
		else $error("Byte add did not clamp high");

	byte_sub_floor_a: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		exec && op_i == SSAU_UNSIGNED_BYTE_SUB && first_i[7:0] < second_i[7:0]
		|=> result_o[7:0] == 8'h00)
		else $error("Byte subtract did not clamp to zero");

	half_sub_floor_a: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		exec && op_i == SSAU_UNSIGNED_HALF_SUB && a_hi < b_hi |=> result_o[31:16] == 16'h0000)
		else $error("Halfword subtract did not floor");

	sx_upper_max_a: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		exec && op_i == SSAU_SIGNED_ADD_SUB_X && !a_hi[15] && !b_lo[15]
		&& (a_hi + b_lo) > SSAU_S16_MAX |=> result_o[31:16] == SSAU_S16_MAX)
		else $error("Signed exchange upper did not clamp");

	sx_lower_min_a: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		exec && op_i == SSAU_SIGNED_ADD_SUB_X && a_lo == SSAU_S16_MIN && !b_hi[15]
		&& b_hi != 16'h0000 |=> result_o[15:0] == SSAU_S16_MIN)
		else $error("Signed exchange lower did not clamp");

	sa_upper_min_a: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		exec && op_i == SSAU_SIGNED_SUB_ADD_X && a_hi == SSAU_S16_MIN && !b_lo[15]
		&& b_lo != 16'h0000 |=> result_o[31:16] == SSAU_S16_MIN)
		else $error("Signed exchange upper did not clamp low");

	sa_lower_max_a: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		exec && op_i == SSAU_SIGNED_SUB_ADD_X && !a_lo[15] && !b_hi[15]
		&& (a_lo + b_hi) > SSAU_S16_MAX |=> result_o[15:0] == SSAU_S16_MAX)
		else $error("Signed exchange lower did not clamp high");

	half_add_top_a: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		exec && op_i == SSAU_UNSIGNED_HALF_ADD && a_lo[15] && b_lo[15]
		|=> result_o[15:0] == SSAU_U16_MAX)
		else $error("Halfword add did not clamp high");

	ux_upper_top_a: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		exec && op_i == SSAU_UNSIGNED_ADD_SUB_X && ({1'b0, a_hi} + {1'b0, b_lo}) > 17'h0_ffff
		|=> result_o[31:16] == SSAU_U16_MAX)
		else $error("Unsigned exchange upper did not clamp high");

	ux_lower_floor_a: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		exec && op_i == SSAU_UNSIGNED_ADD_SUB_X && a_lo < b_hi |=> result_o[15:0] == 16'h0000)
		else $error("Unsigned exchange lower did not floor");

	ux_upper_floor_a: assert property (
		@(posedge ref_clk_i) disable iff (!resetn_i)
		exec && op_i == SSAU_UNSIGNED_SUB_ADD_X && a_hi < b_lo |=> result_o[31:16] == 16'h0000)
		else $error("Unsigned exchange upper did not floor");

endmodule : ssau_unit

// file: bench/ssau_core_model.sv
`timescale 1ns/1ps
module ssau_core_model
	import ssau_pkg::*;
(
	input  wire logic        ref_clk_i,
	output logic             issue_o,
	output logic             cond_pass_o,
	output ssau_op_e         op_o,
	output logic      [31:0] first_o,
	output logic      [31:0] second_o,
	output logic             psr_write_o,
	output logic             psr_q_o,
	output logic      [3:0]  psr_nzcv_o
);
	initial begin
		issue_o     = 1'b0;
		cond_pass_o = 1'b0;
		op_o        = SSAU_OP_NONE;
		first_o     = 32'h0000_0000;
		second_o    = 32'h0000_0000;
		psr_write_o = 1'b0;
		psr_q_o     = 1'b0;
		psr_nzcv_o  = 4'h0;
	end

	// plain operand values
	// Only values leave the issue stage, so no stack or program counter slot exists
	task automatic issue(input ssau_op_e op, input logic [31:0] a, input logic [31:0] b,
		input logic c);
		@(posedge ref_clk_i);
		issue_o     <= 1'b1;
		cond_pass_o <= c;
		op_o        <= op;
		first_o     <= a;
		second_o    <= b;
		@(posedge ref_clk_i);
		issue_o     <= 1'b0;
		// Stale operands inverted so a late sample cannot pass by luck
		first_o     <= ~a;
		second_o    <= ~b;
		cond_pass_o <= ~c;
	endtask : issue

	task automatic psr_set(input logic q, input logic [3:0] f);
		@(posedge ref_clk_i);
		psr_write_o <= 1'b1;
		psr_q_o     <= q;
		psr_nzcv_o  <= f;
		@(posedge ref_clk_i);
		psr_write_o <= 1'b0;
		psr_q_o     <= ~q;
		psr_nzcv_o  <= ~f;
	endtask : psr_set
endmodule : ssau_core_model

// file: bench/tb_saturating_simd_arith_unit.sv
`timescale 1ns/1ps
module tb_saturating_simd_arith_unit
	import ssau_pkg::*;
;
	logic        ref_clk;
	logic        resetn;
	logic        issue;
	logic        cond_pass;
	ssau_op_e    op;
	logic [31:0] first;
	logic [31:0] second;
	logic        psr_write;
	logic        psr_q;
	logic [3:0]  psr_nzcv;
	logic [31:0] result;
	logic        result_valid;
	logic        sticky_q;
	logic [3:0]  nzcv;
	int          miscompares;
	int          check_count;

	ssau_core_model core_u (.ref_clk_i(ref_clk), .issue_o(issue), .cond_pass_o(cond_pass),
		.op_o(op), .first_o(first), .second_o(second), .psr_write_o(psr_write),
		.psr_q_o(psr_q), .psr_nzcv_o(psr_nzcv));
	ssau_unit dut_u (.ref_clk_i(ref_clk), .resetn_i(resetn), .issue_i(issue),
		.cond_pass_i(cond_pass), .op_i(op), .first_i(first), .second_i(second),
		.psr_write_i(psr_write), .psr_q_i(psr_q), .psr_nzcv_i(psr_nzcv), .result_o(result),
		.result_valid_o(result_valid), .sticky_q_o(sticky_q), .nzcv_o(nzcv));

	initial ref_clk = 1'b0;
	always #2 ref_clk = ~ref_clk;

	// ------------------------------
	// Compare and close
	// ------------------------------
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_word

	task automatic chk_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_bit

	task automatic close_out();
		if (miscompares == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : close_out

	task automatic exec(input ssau_op_e o, input logic [31:0] a, input logic [31:0] b,
		input logic [31:0] exp);
		core_u.issue(o, a, b, 1'b1);
		#1;
		chk_bit(result_valid, 1'b1);
		chk_word(result, exp);
	endtask : exec

	// ------------------------------
	// Scenarios
	// ------------------------------
	task automatic t_signed_x();
		core_u.psr_set(1'b0, 4'ha);
		exec(SSAU_SIGNED_ADD_SUB_X, 32'h7000_8000, 32'h1000_2000, 32'h7fff_8000);
		exec(SSAU_SIGNED_ADD_SUB_X, 32'h0003_0005, 32'h0001_0002, 32'h0005_0004);
		exec(SSAU_SIGNED_SUB_ADD_X, 32'h8000_7000, 32'h2000_1000, 32'h8000_7fff);
		exec(SSAU_SIGNED_SUB_ADD_X, 32'h0009_0004, 32'h0002_0001, 32'h0008_0006);
		chk_word(32'(nzcv), 32'h0000_000a);
		chk_bit(sticky_q, 1'b0);
	endtask : t_signed_x

	task automatic t_unsigned_x();
		exec(SSAU_UNSIGNED_ADD_SUB_X, 32'hf000_0010, 32'h0020_2000, 32'hffff_0000);
		exec(SSAU_UNSIGNED_ADD_SUB_X, 32'h0030_0040, 32'h0010_0005, 32'h0035_0030);
		exec(SSAU_UNSIGNED_SUB_ADD_X, 32'h0010_f000, 32'h2000_0020, 32'h0000_ffff);
		exec(SSAU_UNSIGNED_SUB_ADD_X, 32'h0040_0030, 32'h0005_0010, 32'h0030_0035);
		chk_word(32'(nzcv), 32'h0000_000a);
	endtask : t_unsigned_x

	task automatic t_lanes();
		exec(SSAU_UNSIGNED_BYTE_ADD, 32'hff80_1001, 32'h0180_2002, 32'hffff_3003);
		exec(SSAU_UNSIGNED_HALF_ADD, 32'h0001_8000, 32'h0002_9000, 32'h0003_ffff);
		exec(SSAU_UNSIGNED_BYTE_SUB, 32'h0180_1005, 32'h0200_0f06, 32'h0080_0100);
		exec(SSAU_UNSIGNED_HALF_SUB, 32'h0005_9000, 32'h0006_1000, 32'h0000_8000);
	endtask : t_lanes

	task automatic t_double();
		core_u.psr_set(1'b0, 4'h0);
		exec(SSAU_SIGNED_DBL_ADD, 32'h0000_0001, 32'h0000_0002, 32'h0000_0005);
		chk_bit(sticky_q, 1'b0);
		exec(SSAU_SIGNED_DBL_ADD, 32'hffff_ffff, 32'h4000_0000, 32'h7fff_fffe);
		chk_bit(sticky_q, 1'b1);
		exec(SSAU_SIGNED_DBL_ADD, 32'h0000_0001, 32'h0000_0002, 32'h0000_0005);
		chk_bit(sticky_q, 1'b1);
		core_u.psr_set(1'b0, 4'h0);
		#1;
		chk_bit(sticky_q, 1'b0);
		exec(SSAU_SIGNED_DBL_SUB, 32'h8000_0000, 32'h0000_0001, 32'h8000_0000);
		chk_bit(sticky_q, 1'b1);
		exec(SSAU_SIGNED_DBL_SUB, 32'h0000_0009, 32'h0000_0002, 32'h0000_0005);
	endtask : t_double

	task automatic t_refuse();
		core_u.psr_set(1'b0, 4'h0);
		core_u.issue(SSAU_SIGNED_DBL_ADD, 32'h7fff_ffff, 32'h7fff_ffff, 1'b0);
		#1;
		chk_bit(result_valid, 1'b0);
		chk_word(result, 32'h0000_0005);
		chk_bit(sticky_q, 1'b0);
		core_u.issue(SSAU_OP_NONE, 32'h7fff_ffff, 32'h7fff_ffff, 1'b1);
		#1;
		chk_bit(result_valid, 1'b0);
		chk_word(result, 32'h0000_0005);
	endtask : t_refuse

	initial begin
		resetn      = 1'b0;
		miscompares = 0;
		check_count = 0;
		repeat (8) @(posedge ref_clk);
		resetn <= 1'b1;
		#1;
		chk_word(result, 32'h0000_0000);
		chk_bit(sticky_q, 1'b0);
		t_signed_x();
		t_unsigned_x();
		t_lanes();
		t_double();
		t_refuse();
		close_out();
	end

	// Whole run is about 55 cycles; this is far beyond it
	initial begin
		#20000;
		miscompares++;
		close_out();
	end
endmodule : tb_saturating_simd_arith_unit
